/* design/flash_cmd_port.sv */
`timescale 1ns/100ps

module flash_cmd_port
	import flash_port_pkg::*;
#(
	parameter int         ADDR_W       = 17,
	parameter int         MEM_AW       = 8,
	parameter int         ERASE_CNT    = ERASE_CYCLES,
	parameter logic [7:0] MAKER_CODE   = 8'h5a,  // Arbitrary value
	parameter logic [7:0] PART_CODE    = 8'ha5   // Arbitrary value
)
(
	input  wire logic              clk,                   // 100 MHz clock
	input  wire logic              rstn,                  // Async reset, active low
	input  wire logic              high_program_voltage,  // Write mode enabled
	input  wire logic              ce_n,                  // Chip select
	input  wire logic              oe_n,                  // Output strobe
	input  wire logic              we_n,                  // Write strobe
	input  wire logic [ADDR_W-1:0] addr,                  // Parallel address
	input  wire logic [7:0]        data_in,               // Data pins, input
	output      logic [7:0]        data_out,              // Data pins, output
	output      logic              data_oe_n,             // Data pins, drive low
	input  wire logic              sclk,                  // Serial clock
	input  wire logic              sda_in,                // Serial data, input
	output      logic              sda_out,               // Serial data, output
	output      logic              sda_oe_n,              // Serial data, drive low
	output      logic              busy,                  // Program or erase running
	output      logic              serial_mode            // Serial mode selected
);
	localparam int SW = 6 + ADDR_W + 8;
	// Strobes idle high after reset, so the edge detectors see no false edge
	localparam logic [SW-1:0] SYNC_IDLE = {1'b0, 3'h7, 2'h0, ADDR_W'(0), 8'h00};

	serial_link_if link ();

	logic                rst_s1, rst_n_i;
	logic [SW-1:0]       sync1, sync2;
	logic                hpv_s, ce_s, oe_s, we_s, sclk_s, sda_s;
	logic [ADDR_W-1:0]   addr_s;
	logic [7:0]          din_s;
	logic                hpv_q, oe_q, we_q;
	logic                we_rise, we_fall, oe_fall;
	logic [7:0]          mem [2**MEM_AW];

	par_state_t          pstate, next_pstate;
	ser_state_t          sstate, next_sstate;
	op_t                 op, next_op;
	logic [7:0]          cmd, next_cmd, scmd, next_scmd, err, next_err;
	logic [ADDR_W-1:0]   wr_addr, next_wr_addr, ev_addr, next_ev_addr;
	logic [MEM_AW-1:0]   prog_addr, next_prog_addr;
	logic [7:0]          prog_data, next_prog_data;
	logic [15:0]         saddr, next_saddr;
	logic [TIMER_W-1:0]  timer, next_timer;
	logic                next_serial_mode, next_busy, next_data_oe_n, next_sda_oe_n;
	logic [7:0]          next_data_out;

	function automatic logic [7:0] ident(input logic [ADDR_W-1:0] a);
		if (a == ADDR_W'(ID_ADDR_MAKER))
			return MAKER_CODE;
		else if (a == ADDR_W'(ID_ADDR_PART))
			return PART_CODE;
		else
			return 8'h00;
	endfunction : ident

	////////////////////////////////////////////////////////////////////////
	// Reset release and pin synchronisers

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rst_s1  <= 1'b0;
			rst_n_i <= 1'b0;
		end
		else
		begin
			rst_s1  <= 1'b1;
			rst_n_i <= rst_s1;
		end
	end

	always_ff @(posedge clk or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			sync1 <= SYNC_IDLE;
			sync2 <= SYNC_IDLE;
			hpv_q <= 1'b0;
			oe_q  <= 1'b1;
			we_q  <= 1'b1;
		end
		else
		begin
			sync1 <= {high_program_voltage, ce_n, oe_n, we_n, sclk, sda_in, addr, data_in};
			sync2 <= sync1;
			hpv_q <= hpv_s;
			oe_q  <= oe_s;
			we_q  <= we_s;
		end
	end

	assign {hpv_s, ce_s, oe_s, we_s, sclk_s, sda_s, addr_s, din_s} = sync2;
	assign we_rise = we_s & ~we_q;
	assign we_fall = ~we_s & we_q;
	assign oe_fall = ~oe_s & oe_q;

	assign link.sclk    = sclk_s;
	assign link.sda     = sda_s;
	assign link.clear   = ~serial_mode;
	assign link.tx_load = (sstate == S_OE) && oe_fall;
	assign link.tx_byte = (scmd == CMD_ERRCHK) ? err :
	                      (scmd == CMD_PVERIFY) ? mem[prog_addr] : mem[saddr[MEM_AW-1:0]];

	serial_shifter u_shifter (
		.clk   (clk),
		.rst_n (rst_n_i),
		.link  (link.shifter)
	);

	////////////////////////////////////////////////////////////////////////
	// Command sequencing

	always_comb
	begin
		next_pstate      = pstate;
		next_sstate      = sstate;
		next_op          = op;
		next_cmd         = cmd;
		next_scmd        = scmd;
		next_err         = err;
		next_wr_addr     = we_fall ? addr_s : wr_addr;
		next_ev_addr     = ev_addr;
		next_prog_addr   = prog_addr;
		next_prog_data   = prog_data;
		next_saddr       = saddr;
		next_timer       = timer;
		next_serial_mode = serial_mode;
		if (hpv_s && !hpv_q)
			next_serial_mode = sclk_s & sda_s & oe_s;
		else if (!hpv_s)
			next_serial_mode = 1'b0;

		// Operation timer; array only changes at completion, so cancel is clean
		if (op != OP_NONE)
		begin
			if (timer == '0)
				next_op = OP_NONE;
			else
				next_timer = timer - TIMER_W'(1);
		end

		if (!hpv_s)
		begin
			next_pstate = P_FIRST;
			next_cmd    = CMD_READ;
			next_sstate = S_CMD;
		end
		else if (!serial_mode && we_rise && op == OP_NONE)
		begin
			case (pstate)
				P_FIRST:
				begin
					next_cmd = din_s;
					if (din_s == CMD_PROG || din_s == CMD_ERASE)
						next_pstate = P_SECOND;
					if (din_s == CMD_EVERIFY)
						next_ev_addr = wr_addr;
				end
				P_SECOND:
				begin
					next_pstate = P_FIRST;
					if (din_s == CMD_CANCEL)
						next_pstate = P_THIRD;
					else if (cmd == CMD_PROG)
					begin
						next_op        = OP_PROG;
						next_timer     = TIMER_W'(PROG_CYCLES - 1);
						next_prog_addr = wr_addr[MEM_AW-1:0];
						next_prog_data = din_s;
					end
					else if (din_s == CMD_ERASE)
					begin
						next_op    = OP_ERASE;
						next_timer = TIMER_W'(ERASE_CNT - 1);
					end
					else
						next_cmd = CMD_READ;
				end
				default:
				begin
					// Whatever the third byte is, nothing is started
					next_pstate = P_FIRST;
					next_cmd    = CMD_READ;
				end
			endcase
		end
		else if (serial_mode && link.rx_valid && op == OP_NONE)
		begin
			case (sstate)
				S_CMD:
				begin
					next_scmd = link.rx_byte;
					case (link.rx_byte)
						CMD_READ, CMD_PROG, CMD_EVERIFY: next_sstate = S_ADL;
						CMD_PVERIFY, CMD_ERRCHK:         next_sstate = S_OE;
						CMD_ERASE:                       next_sstate = S_ERASE2;
						default:                         next_err    = ERR_BAD_CMD;
					endcase
				end
				S_ADL:
				begin
					next_saddr  = {saddr[15:8], link.rx_byte};
					next_sstate = S_ADH;
				end
				S_ADH:
				begin
					next_saddr  = {link.rx_byte, saddr[7:0]};
					next_sstate = (scmd == CMD_PROG) ? S_DATA : S_OE;
				end
				S_DATA:
				begin
					next_op        = OP_PROG;
					next_timer     = TIMER_W'(PROG_CYCLES - 1);
					next_prog_addr = saddr[MEM_AW-1:0];
					next_prog_data = link.rx_byte;
					next_sstate    = S_CMD;
				end
				S_ERASE2:
				begin
					if (link.rx_byte == CMD_ERASE)
					begin
						next_op    = OP_ERASE;
						next_timer = TIMER_W'(ERASE_CNT - 1);
					end
					next_sstate = S_CMD;
				end
				S_TX:
					next_sstate = S_CMD;
				default:
					next_sstate = sstate;
			endcase
		end
		else if (serial_mode && link.tx_load)
		begin
			next_sstate = S_TX;
			if (scmd == CMD_ERRCHK)
				next_err = ERR_NONE;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin drivers

	always_comb
	begin
		case (cmd)
			CMD_IDENT:   next_data_out = ident(addr_s);
			CMD_PVERIFY: next_data_out = mem[prog_addr];
			CMD_EVERIFY: next_data_out = mem[ev_addr[MEM_AW-1:0]];
			default:     next_data_out = mem[addr_s[MEM_AW-1:0]];
		endcase
		next_data_oe_n = ~(~serial_mode & ~ce_s & ~oe_s & we_s);
		next_sda_oe_n  = ~(serial_mode & (sstate == S_TX) & oe_s);
		next_busy      = (next_op != OP_NONE);
	end

	always_ff @(posedge clk)
	begin
		if (op != OP_NONE && timer == '0)
		begin
			if (op == OP_PROG)
				mem[prog_addr] <= prog_data;
			else
				for (int i = 0; i < 2**MEM_AW; i++)
					mem[i] <= ERASED_BYTE;
		end
	end

	always_ff @(posedge clk or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			pstate      <= P_FIRST;
			sstate      <= S_CMD;
			op          <= OP_NONE;
			cmd         <= CMD_READ;
			scmd        <= CMD_READ;
			err         <= ERR_NONE;
			wr_addr     <= '0;
			ev_addr     <= '0;
			prog_addr   <= '0;
			prog_data   <= 8'h00;
			saddr       <= 16'h0000;
			timer       <= '0;
			serial_mode <= 1'b0;
			busy        <= 1'b0;
			data_out    <= 8'h00;
			data_oe_n   <= 1'b1;
			sda_out     <= 1'b0;
			sda_oe_n    <= 1'b1;
		end
		else
		begin
			pstate      <= next_pstate;
			sstate      <= next_sstate;
			op          <= next_op;
			cmd         <= next_cmd;
			scmd        <= next_scmd;
			err         <= next_err;
			wr_addr     <= next_wr_addr;
			ev_addr     <= next_ev_addr;
			prog_addr   <= next_prog_addr;
			prog_data   <= next_prog_data;
			saddr       <= next_saddr;
			timer       <= next_timer;
			serial_mode <= next_serial_mode;
			busy        <= next_busy;
			data_out    <= next_data_out;
			data_oe_n   <= next_data_oe_n;
			sda_out     <= link.tx_bit;
			sda_oe_n    <= next_sda_oe_n;
		end
	end
endmodule : flash_cmd_port

/* design/flash_port_pkg.sv */
package flash_port_pkg;

	localparam logic [7:0] CMD_READ    = 8'h00;
	localparam logic [7:0] CMD_PROG    = 8'h40;
	localparam logic [7:0] CMD_PVERIFY = 8'hc0;
	localparam logic [7:0] CMD_ERASE   = 8'h20;
	localparam logic [7:0] CMD_EVERIFY = 8'ha0;
	localparam logic [7:0] CMD_CANCEL  = 8'hff;
	localparam logic [7:0] CMD_IDENT   = 8'h90;
	localparam logic [7:0] CMD_ERRCHK  = 8'h80;

	localparam logic [16:0] ID_ADDR_MAKER = 17'h00000;
	localparam logic [16:0] ID_ADDR_PART  = 17'h00001;

	localparam logic [7:0] ERASED_BYTE   = 8'hff;
	localparam logic [7:0] ERR_NONE      = 8'h00;
	localparam logic [7:0] ERR_BAD_CMD   = 8'h01;

	localparam int CLK_MHZ           = 100;
	localparam int PROG_TIME_US      = 10;
	localparam int PROG_CYCLES       = PROG_TIME_US * CLK_MHZ;
	localparam int ERASE_TIME_MS_X10 = 95;
	localparam int ERASE_CYCLES      = (ERASE_TIME_MS_X10 * CLK_MHZ * 1000) / 10;
	localparam int TIMER_W           = 20;
	localparam int SYNC_STAGES       = 2;

	typedef enum logic [1:0] {P_FIRST, P_SECOND, P_THIRD} par_state_t;
	typedef enum logic [2:0] {S_CMD, S_ADL, S_ADH, S_DATA, S_ERASE2, S_OE, S_TX} ser_state_t;
	typedef enum logic [1:0] {OP_NONE, OP_PROG, OP_ERASE} op_t;

endpackage : flash_port_pkg

/* design/serial_link_if.sv */
`timescale 1ns/100ps

interface serial_link_if;
	logic       sclk;
	logic       sda;
	logic       clear;
	logic       tx_load;
	logic [7:0] tx_byte;
	logic       tx_bit;
	logic       rx_valid;
	logic [7:0] rx_byte;

	modport ctrl (output sclk, sda, clear, tx_load, tx_byte, input tx_bit, rx_valid, rx_byte);
	modport shifter (input sclk, sda, clear, tx_load, tx_byte, output tx_bit, rx_valid, rx_byte);
endinterface : serial_link_if

/* design/serial_shifter.sv */
`timescale 1ns/100ps

module serial_shifter
(
	input wire logic       clk,     // System clock
	input wire logic       rst_n,   // Synchronised reset
	serial_link_if.shifter link     // Byte side and synced pins
);
	logic       sclk_q;
	logic [2:0] cnt;
	logic [7:0] sh_in;
	logic [7:0] sh_out;
	logic       rx_valid;
	logic [7:0] rx_byte;
	logic [2:0] next_cnt;
	logic [7:0] next_sh_in;
	logic [7:0] next_sh_out;
	logic       next_rx_valid;
	logic [7:0] next_rx_byte;
	logic       rise;
	logic       fall;

	assign rise          = link.sclk & ~sclk_q;
	assign fall          = ~link.sclk & sclk_q;
	assign link.tx_bit   = sh_out[0];
	assign link.rx_valid = rx_valid;
	assign link.rx_byte  = rx_byte;

	always_comb
	begin
		next_cnt      = cnt;
		next_sh_in    = sh_in;
		next_sh_out   = sh_out;
		next_rx_valid = 1'b0;
		next_rx_byte  = rx_byte;
		if (link.clear || link.tx_load)
		begin
			next_cnt = 3'h0;
			if (link.tx_load)
				next_sh_out = link.tx_byte;
		end
		else
		begin
			if (rise)
			begin
				next_sh_in = {link.sda, sh_in[7:1]};
				next_cnt   = cnt + 3'h1;
				if (cnt == 3'h7)
				begin
					next_rx_valid = 1'b1;
					next_rx_byte  = {link.sda, sh_in[7:1]};
				end
			end
			if (fall)
				next_sh_out = {1'b0, sh_out[7:1]};
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sclk_q   <= 1'b1;
			cnt      <= 3'h0;
			sh_in    <= 8'h00;
			sh_out   <= 8'h00;
			rx_valid <= 1'b0;
			rx_byte  <= 8'h00;
		end
		else
		begin
			sclk_q   <= link.sclk;
			cnt      <= next_cnt;
			sh_in    <= next_sh_in;
			sh_out   <= next_sh_out;
			rx_valid <= next_rx_valid;
			rx_byte  <= next_rx_byte;
		end
	end
endmodule : serial_shifter

/* testbench/flash_cmd_port_properties.sv */
`timescale 1ns/100ps

module flash_cmd_port_properties
	import flash_port_pkg::*;
#(
	parameter int ERASE_CNT = ERASE_CYCLES
)
(
	input wire logic clk,                  // Clock
	input wire logic rstn,                 // Reset, active low
	input wire logic high_program_voltage, // Write mode
	input wire logic oe_n,                 // Output strobe
	input wire logic we_n,                 // Write strobe
	input wire logic sclk,                 // Serial clock
	input wire logic data_oe_n,            // Data drive, low
	input wire logic sda_oe_n,             // Serial drive, low
	input wire logic busy,                 // Timer running
	input wire logic serial_mode           // Serial selected
);
	logic [19:0] run;
	logic [19:0] next_run;
	logic [3:0]  since;
	logic [3:0]  next_since;
	logic        we_d;
	logic        sclk_d;

////////////////////////////////
	always_comb
	begin
		next_run = busy ? run + 20'h1 : 20'h0;
		next_since = (since == 4'hf) ? since : since + 4'h1;
		if ((we_n && !we_d) || (sclk && !sclk_d))
			next_since = 4'h0;
	end

	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
		begin
			run <= 20'h0;
			since <= 4'hf;
			we_d <= 1'b1;
			sclk_d <= 1'b1;
		end
		else
		begin
			run <= next_run;
			since <= next_since;
			we_d <= we_n;
			sclk_d <= sclk;
		end

////////////////////////////////
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	a_drive_needs_strobe: assert property (oe_n [*6] |-> data_oe_n)
		else $error("data pins driven with output strobe high");
	a_par_quiet_serial: assert property (serial_mode |-> data_oe_n)
		else $error("data pins driven in serial mode");
	a_ser_quiet_par: assert property (!serial_mode |-> sda_oe_n)
		else $error("serial pin driven in parallel mode");
	a_sda_after_oe: assert property (!sda_oe_n |-> oe_n)
		else $error("serial pin driven with output strobe low");
	a_busy_length: assert property ($fell(busy) |-> (run >= PROG_CYCLES - 2
		&& run <= PROG_CYCLES + 2) || (run >= ERASE_CNT - 2 && run <= ERASE_CNT + 2))
		else $error("busy time differs from timer length");
	a_busy_cause: assert property ($rose(busy) |-> since <= 4'h8)
		else $error("busy rose without a strobe or clock rise");
	a_busy_needs_hpv: assert property ($rose(busy) |-> high_program_voltage)
		else $error("busy rose without programming voltage");
	a_mode_entry: assert property ($rose(serial_mode) |-> high_program_voltage
		&& oe_n && sclk)
		else $error("serial mode entered without pins high");
	a_mode_holds: assert property (serial_mode && high_program_voltage |=> serial_mode)
		else $error("serial mode dropped");

	c_busy: cover property ($rose(busy));
	c_serial: cover property ($rose(serial_mode));
	c_drive: cover property ($fell(data_oe_n));
	c_sda: cover property ($fell(sda_oe_n));
endmodule : flash_cmd_port_properties

bind flash_cmd_port flash_cmd_port_properties #(.ERASE_CNT(ERASE_CNT)) i_flash_cmd_port_properties
(
	.clk(clk), .rstn(rstn), .high_program_voltage(high_program_voltage),
	.oe_n(oe_n), .we_n(we_n), .sclk(sclk), .data_oe_n(data_oe_n),
	.sda_oe_n(sda_oe_n), .busy(busy), .serial_mode(serial_mode)
);

/* testbench/programmer.sv */
`timescale 1ns/100ps

module programmer
(
	input  wire logic        clk,                  // Bench clock
	output      logic        high_program_voltage, // Write mode
	output      logic        ce_n,                 // Chip select
	output      logic        oe_n,                 // Output strobe
	output      logic        we_n,                 // Write strobe
	output      logic [16:0] addr,                 // Address
	output      logic [7:0]  data_in,              // Data to device
	output      logic        sclk,                 // Serial clock
	output      logic        sda_in,               // Serial data out
	input  wire logic [7:0]  data_out,             // Data from device
	input  wire logic        data_oe_n,            // Device drives data
	input  wire logic        sda_out,              // Serial data in
	input  wire logic        sda_oe_n              // Device drives serial data
);
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	task automatic par_write(input logic [16:0] a, input logic [7:0] d);
		addr = a;
		data_in = d;
		ce_n = 1'b0;
		tick(2);
		we_n = 1'b0;
		tick(6);
		we_n = 1'b1;
		tick(6);
		ce_n = 1'b1;
		data_in = ~d; // Released bus, stale value inverted
		tick(2);
	endtask : par_write

	task automatic par_read(input logic [16:0] a, output logic [7:0] d, output logic drv);
		addr = a;
		ce_n = 1'b0;
		oe_n = 1'b0;
		tick(8);
		d = data_out;
		drv = data_oe_n;
		oe_n = 1'b1;
		ce_n = 1'b1;
		tick(6);
	endtask : par_read

	task automatic set_mode(input logic ser);
		high_program_voltage = 1'b0;
		tick(4);
		sclk = ser;
		sda_in = ser;
		oe_n = 1'b1;
		tick(4);
		high_program_voltage = 1'b1;
		tick(8);
	endtask : set_mode

	task automatic ser_byte(input logic [7:0] b);
		for (int i = 0; i < 8; i++)
		begin
			sclk = 1'b0;
			sda_in = b[i];
			#62.5;
			sclk = 1'b1;
			#62.5;
		end
		sda_in = ~b[7];
	endtask : ser_byte

	task automatic ser_read(output logic [7:0] b, output logic drv);
		oe_n = 1'b0;
		#250;
		oe_n = 1'b1;
		#250;
		drv = sda_oe_n;
		for (int i = 0; i < 8; i++)
		begin
			b[i] = sda_out;
			sclk = 1'b0;
			#62.5;
			sclk = 1'b1;
			#62.5;
		end
	endtask : ser_read

	initial
	begin
		high_program_voltage = 1'b0;
		{ce_n, oe_n, we_n} = 3'h7;
		addr = 17'h0;
		data_in = 8'h0;
		sclk = 1'b0;
		sda_in = 1'b0;
	end
endmodule : programmer

/* testbench/flash_cmd_port_tb.sv */
`timescale 1ns/100ps

module flash_cmd_port_tb import flash_port_pkg::*;;
	localparam logic [7:0] MAKER = 8'h3c; // Arbitrary value
	localparam logic [7:0] PART  = 8'hc3; // Arbitrary value
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	wire logic        hpv, ce_n, oe_n, we_n, sclk, sda_in, sda_out, sda_oe_n;
	wire logic        busy, serial_mode, data_oe_n;
	wire logic [16:0] addr;
	wire logic [7:0]  data_in, data_out;
	logic             drv;
	logic [7:0]       d;
	int          failures = 0;
	int          total_checks = 0;

	always #5 clk = ~clk;

	flash_cmd_port #(.ERASE_CNT(50), .MAKER_CODE(MAKER), .PART_CODE(PART)) i_flash_cmd_port
	(
		.clk(clk), .rstn(rstn), .high_program_voltage(hpv), .ce_n(ce_n), .oe_n(oe_n),
		.we_n(we_n), .addr(addr), .data_in(data_in), .data_out(data_out),
		.data_oe_n(data_oe_n), .sclk(sclk), .sda_in(sda_in), .sda_out(sda_out),
		.sda_oe_n(sda_oe_n), .busy(busy), .serial_mode(serial_mode)
	);

	programmer i_programmer
	(
		.clk(clk), .high_program_voltage(hpv), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
		.addr(addr), .data_in(data_in), .sclk(sclk), .sda_in(sda_in),
		.data_out(data_out), .data_oe_n(data_oe_n), .sda_out(sda_out), .sda_oe_n(sda_oe_n)
	);

////////////////////////////////
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic stop_test();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : stop_test

	task automatic t_ident();
		i_programmer.par_write(17'h0, CMD_IDENT);
		i_programmer.par_read(ID_ADDR_MAKER, d, drv);
		check(d, MAKER);
		check(drv, 1'b0);
		i_programmer.par_read(ID_ADDR_PART, d, drv);
		check(d, PART);
		check(data_oe_n, 1'b1);
		$display("ident done");
	endtask : t_ident

	task automatic t_program();
		i_programmer.par_write(17'h0, CMD_PROG);
		i_programmer.par_write(17'h5, 8'h96);
		i_programmer.tick(985);
		check(busy, 1'b1);
		i_programmer.tick(20);
		check(busy, 1'b0);
		i_programmer.par_write(17'h0, CMD_PVERIFY);
		i_programmer.par_read(17'h0, d, drv);
		check(d, 8'h96);
		i_programmer.par_write(17'h0, CMD_READ);
		repeat (2)
		begin
			i_programmer.par_read(17'h5, d, drv);
			check(d, 8'h96);
		end
		$display("program done");
	endtask : t_program

	task automatic t_cancel();
		logic [7:0] ops[2] = '{CMD_PROG, CMD_ERASE};
		logic [7:0] thirds[2] = '{CMD_CANCEL, CMD_READ};
		foreach (thirds[t])
			foreach (ops[k])
			begin
				i_programmer.par_write(17'h5, ops[k]);
				i_programmer.par_write(17'h5, CMD_CANCEL);
				i_programmer.par_write(17'h5, thirds[t]);
				check(busy, 1'b0);
				i_programmer.par_read(17'h5, d, drv);
				check(d, 8'h96);
			end
		$display("cancel done");
	endtask : t_cancel

	task automatic t_erase();
		i_programmer.par_write(17'h0, CMD_ERASE);
		i_programmer.par_write(17'h0, CMD_ERASE);
		check(busy, 1'b1);
		i_programmer.tick(60);
		i_programmer.par_write(17'h5, CMD_EVERIFY);
		i_programmer.par_read(17'h5, d, drv);
		check(d, ERASED_BYTE);
		$display("erase done");
	endtask : t_erase

	task automatic ser_cmd(input logic [7:0] c, input logic [7:0] al, input logic full);
		i_programmer.ser_byte(c);
		if (full)
		begin
			i_programmer.ser_byte(al);
			i_programmer.ser_byte(8'h00);
		end
	endtask : ser_cmd

	task automatic t_serial();
		i_programmer.set_mode(1'b1);
		check(serial_mode, 1'b1);
		ser_cmd(CMD_PROG, 8'h07, 1'b1);
		i_programmer.ser_byte(8'h4b);
		i_programmer.tick(4);
		check(busy, 1'b1);
		i_programmer.tick(1010);
		ser_cmd(CMD_READ, 8'h07, 1'b1);
		i_programmer.ser_read(d, drv);
		check(d, 8'h4b);
		check(drv, 1'b0);
		ser_cmd(CMD_READ, 8'h05, 1'b1);
		i_programmer.ser_read(d, drv);
		check(d, ERASED_BYTE);
		i_programmer.tick(2);
		check(sda_oe_n, 1'b1);
		ser_cmd(CMD_PVERIFY, 8'h00, 1'b0);
		i_programmer.ser_read(d, drv);
		check(d, 8'h4b);
		ser_cmd(CMD_ERASE, CMD_ERASE, 1'b0);
		i_programmer.ser_byte(CMD_ERASE);
		i_programmer.tick(60);
		ser_cmd(CMD_EVERIFY, 8'h07, 1'b1);
		i_programmer.ser_read(d, drv);
		check(d, ERASED_BYTE);
		ser_cmd(8'h11, 8'h00, 1'b0);
		ser_cmd(CMD_ERRCHK, 8'h00, 1'b0);
		i_programmer.ser_read(d, drv);
		check(d, ERR_BAD_CMD);
		$display("serial done");
	endtask : t_serial

////////////////////////////////
	initial
	begin
		repeat (4) @(posedge clk);
		#1;
		rstn = 1'b1;
		i_programmer.set_mode(1'b0);
		check(serial_mode, 1'b0);
		t_ident();
		t_program();
		t_cancel();
		t_erase();
		t_serial();
		stop_test();
	end

	initial
	begin
		#300us;
		failures++;
		stop_test();
	end
endmodule : flash_cmd_port_tb
